// File: pcc_call_ctrl.sv
`timescale 1ns/100ps
module pcc_call_ctrl
   import pcc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_req_valid,
   input wire pcc_pkg::pcc_req_type i_req,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   output logic o_busy,
   output pcc_pkg::pcc_mem_req_type o_mem,
   output logic o_res_valid,
   output pcc_pkg::pcc_res_type o_res
);
   import pcc_pkg::*;

   pcc_state_type state_ff, nxt_state;
   pcc_req_type req_ff, nxt_req;
   pcc_mem_req_type mem_ff, nxt_mem;
   pcc_res_type res_ff, nxt_res;
   logic res_valid_ff, nxt_res_valid;
   logic busy_ff, nxt_busy;
   logic [31:0] tgt_eip_ff, nxt_tgt_eip;
   logic [15:0] tgt_cs_ff, nxt_tgt_cs;
   logic [15:0] sel_ff, nxt_sel;
   logic [31:0] lo_ff, nxt_lo;
   logic [31:0] sp_ff, nxt_sp;
   logic [15:0] ss_new_ff, nxt_ss_new;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [1:0] step_ff, nxt_step;
   logic wide_ff, nxt_wide;
   logic [31:0] data_ff, nxt_data;

   pcc_kind_type kind;
   logic [31:0] near_target;
   logic [31:0] psize, osize, room, ea, desc_addr, push_val, gsize;
   logic fault_now;
   logic [7:0] fault_vec;
   logic [15:0] fault_err;
   logic finish_ok;
   logic [3:0] dtype;

   pcc_decode u_decode (
      .i_req(req_ff),
      .o_kind(kind),
      .o_near_target(near_target)
   );

   // sequencer: decode, descriptor walk, pushes and parameter copy
   always_comb
   begin
      nxt_state = state_ff;
      nxt_req = req_ff;
      nxt_mem = mem_ff;
      nxt_res = res_ff;
      nxt_res_valid = 1'b0;
      nxt_busy = busy_ff;
      nxt_tgt_eip = tgt_eip_ff;
      nxt_tgt_cs = tgt_cs_ff;
      nxt_sel = sel_ff;
      nxt_lo = lo_ff;
      nxt_sp = sp_ff;
      nxt_ss_new = ss_new_ff;
      nxt_cnt = cnt_ff;
      nxt_step = step_ff;
      nxt_wide = wide_ff;
      nxt_data = data_ff;
      fault_now = 1'b0;
      fault_vec = VEC_GP;
      fault_err = 16'h0000;
      finish_ok = 1'b0;
      psize = wide_ff ? SZ32 : SZ16;
      osize = req_ff.op32 ? SZ32 : SZ16;
      gsize = i_mem_rdata[DESC_TYPE_MSB] ? SZ32 : SZ16;
      room = (req_ff.stack_pointer > req_ff.stack_limit) ? req_ff.stack_pointer - req_ff.stack_limit : 32'h0000_0000; // no wrap
      ea = req_ff.base_is_sp ? req_ff.stack_pointer + req_ff.rm_value : req_ff.rm_value;
      desc_addr = req_ff.gdt_base + {16'h0000, sel_ff[15:3], 3'h0};
      dtype = i_mem_rdata[DESC_TYPE_MSB:DESC_TYPE_LSB];
      unique case (step_ff)
         2'h0: push_val = {16'h0000, req_ff.ss};
         2'h1: push_val = req_ff.stack_pointer;
         2'h2: push_val = {16'h0000, req_ff.cs};
         2'h3: push_val = req_ff.next_eip;
      endcase
      // memory request is held until acknowledged
      if (mem_ff.valid && i_mem_ack)
         nxt_mem.valid = 1'b0;
      unique case (state_ff)
         ST_IDLE:
            if (i_req_valid)
            begin
               nxt_req = i_req;
               nxt_busy = 1'b1;
               nxt_state = ST_DECODE;
            end
         ST_DECODE:
         begin
            nxt_wide = req_ff.op32;
            nxt_sp = req_ff.stack_pointer;
            nxt_ss_new = req_ff.ss;
            nxt_tgt_cs = req_ff.cs;
            nxt_cnt = 5'h00;
            nxt_tgt_eip = near_target;
            unique case (kind)
               K_NEAR_REL, K_NEAR_ABS:
                  if (kind == K_NEAR_ABS && req_ff.rm_is_mem)
                     nxt_state = ST_NEAR_RD;
                  else if (room < osize)
                     fault_now = 1'b1;
                  else
                  begin
                     nxt_step = STEP_RET_PTR;
                     nxt_state = ST_PUSH;
                  end
               K_FAR_IMM:
               begin
                  nxt_tgt_eip = req_ff.imm;
                  nxt_sel = req_ff.imm_sel;
                  nxt_state = ST_FAR_CHK;
               end
               K_FAR_MEM:
                  nxt_state = ST_FPTR_OFF;
               K_ILLEGAL:
               begin
                  fault_now = 1'b1;
                  fault_vec = VEC_UD;
               end
            endcase
            if (fault_now && kind != K_ILLEGAL)
               fault_vec = VEC_SS;
         end
         ST_NEAR_RD:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, req_ff.op32, ea, 32'h0};
            else if (i_mem_ack)
            begin
               nxt_tgt_eip = req_ff.op32 ? i_mem_rdata : {LOW_MASK16, i_mem_rdata[15:0]};
               if (room < osize)
               begin
                  fault_now = 1'b1;
                  fault_vec = VEC_SS;
               end
               else
               begin
                  nxt_step = STEP_RET_PTR;
                  nxt_state = ST_PUSH;
               end
            end
         ST_FPTR_OFF:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, req_ff.op32, ea, 32'h0};
            else if (i_mem_ack)
            begin
               nxt_tgt_eip = i_mem_rdata;
               nxt_state = ST_FPTR_SEL;
            end
         ST_FPTR_SEL:
            // selector follows the 2- or 4-byte offset in memory
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, 1'b0, ea + osize, 32'h0};
            else if (i_mem_ack)
            begin
               nxt_sel = i_mem_rdata[15:0];
               nxt_state = ST_FAR_CHK;
            end
         ST_FAR_CHK:
            if (!req_ff.prot_mode)
            begin
               nxt_tgt_cs = sel_ff;
               if (room < (osize << 1))
               begin
                  fault_now = 1'b1;
                  fault_vec = VEC_SS;
               end
               else
               begin
                  nxt_step = STEP_CODE_SEL;
                  nxt_state = ST_PUSH;
               end
            end
            else if (sel_ff[15:2] == 14'h0000)
               fault_now = 1'b1;
            else
               nxt_state = ST_DESC_LO;
         ST_DESC_LO:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, 1'b1, desc_addr, 32'h0};
            else if (i_mem_ack)
            begin
               nxt_lo = i_mem_rdata;
               nxt_state = ST_DESC_HI;
            end
         ST_DESC_HI:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, 1'b1, desc_addr + DESC_HI_OFFSET, 32'h0};
            else if (i_mem_ack)
            begin
               // descriptor type decides the flavour of far call
               if (i_mem_rdata[DESC_S_BIT] && dtype[3])
               begin
                  nxt_tgt_cs = {sel_ff[15:2], req_ff.cpl};
                  if (room < (osize << 1))
                  begin
                     fault_now = 1'b1;
                     fault_vec = VEC_SS;
                  end
                  else
                  begin
                     nxt_step = STEP_CODE_SEL;
                     nxt_state = ST_PUSH;
                  end
               end
               else if (!i_mem_rdata[DESC_S_BIT] && dtype[2:0] == TYPE_CALL_GATE)
               begin
                  nxt_tgt_cs = lo_ff[31:16];
                  nxt_wide = dtype[3];
                  if (lo_ff[31:18] == 14'h0000)
                     fault_now = 1'b1;
                  else if (lo_ff[17:16] < req_ff.cpl)
                  begin
                     nxt_cnt = i_mem_rdata[DESC_PCNT_MSB:0];
                     nxt_state = ST_TSS_SP;
                  end
                  else if (room < (gsize << 1))
                  begin
                     fault_now = 1'b1;
                     fault_vec = VEC_SS;
                  end
                  else
                  begin
                     nxt_step = STEP_CODE_SEL;
                     nxt_state = ST_PUSH;
                  end
               end
               else if (!i_mem_rdata[DESC_S_BIT] && (dtype == TYPE_TASK_GATE || dtype == TYPE_TSS16
                  || dtype == TYPE_TSS32))
               begin
                  // task switch mechanics live outside; hand over the segment
                  nxt_res = '{req_ff.cur_eip, req_ff.cs, req_ff.stack_pointer, req_ff.ss, 1'b0, 8'h00, 16'h0000, 1'b1,
                     (dtype == TYPE_TASK_GATE) ? lo_ff[31:16] : sel_ff};
                  nxt_res_valid = 1'b1;
                  nxt_busy = 1'b0;
                  nxt_state = ST_IDLE;
               end
               else
               begin
                  fault_now = 1'b1;
                  fault_err = {sel_ff[15:2], 2'h0};
               end
            end
         ST_TSS_SP:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, 1'b1, req_ff.tss_base + {27'h0, tgt_cs_ff[1:0], 3'h0} + TSS_SP_OFFSET,
                  32'h0};
            else if (i_mem_ack)
            begin
               nxt_sp = i_mem_rdata;
               nxt_state = ST_TSS_SS;
            end
         ST_TSS_SS:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, 1'b1, req_ff.tss_base + {27'h0, tgt_cs_ff[1:0], 3'h0} + TSS_SS_OFFSET,
                  32'h0};
            else if (i_mem_ack)
            begin
               nxt_ss_new = i_mem_rdata[15:0];
               nxt_step = STEP_OLD_SS;
               nxt_state = ST_PUSH;
            end
         ST_PUSH:
            // selectors widen to four bytes on a 32-bit push
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b1, wide_ff, sp_ff - psize, push_val};
            else if (i_mem_ack)
            begin
               nxt_sp = sp_ff - psize;
               nxt_step = step_ff + 2'h1;
               if (step_ff == 2'h1 && cnt_ff != 5'h00)
                  nxt_state = ST_COPY_RD;
               else if (step_ff == STEP_RET_PTR)
                  finish_ok = 1'b1;
            end
         ST_COPY_RD:
            // deepest parameter first keeps the caller's layout
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b0, wide_ff, req_ff.stack_pointer + (({27'h0, cnt_ff} - 32'h1) << (wide_ff ? 2 : 1)),
                  32'h0};
            else if (i_mem_ack)
            begin
               nxt_data = i_mem_rdata;
               nxt_state = ST_COPY_WR;
            end
         ST_COPY_WR:
            if (!mem_ff.valid)
               nxt_mem = '{1'b1, 1'b1, wide_ff, sp_ff - psize, data_ff};
            else if (i_mem_ack)
            begin
               nxt_sp = sp_ff - psize;
               nxt_cnt = cnt_ff - 5'h01;
               if (cnt_ff == 5'h01)
                  nxt_state = ST_PUSH;
               else
                  nxt_state = ST_COPY_RD;
            end
         default:
            nxt_state = ST_IDLE;
      endcase
      // commit only at the end, so a fault leaves state untouched
      if (finish_ok)
      begin
         nxt_res = '{wide_ff ? tgt_eip_ff : {LOW_MASK16, tgt_eip_ff[15:0]}, tgt_cs_ff, nxt_sp, ss_new_ff,
            1'b0, 8'h00, 16'h0000, 1'b0, 16'h0000};
         nxt_res_valid = 1'b1;
         nxt_busy = 1'b0;
         nxt_state = ST_IDLE;
      end
      if (fault_now)
      begin
         nxt_res = '{req_ff.cur_eip, req_ff.cs, req_ff.stack_pointer, req_ff.ss, 1'b1, fault_vec, fault_err, 1'b0,
            16'h0000};
         nxt_res_valid = 1'b1;
         nxt_busy = 1'b0;
         nxt_state = ST_IDLE;
      end
   end

   // registers only
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         state_ff <= ST_IDLE;
         req_ff <= REQ_RESET;
         mem_ff <= MEM_RESET;
         res_ff <= RES_RESET;
         res_valid_ff <= 1'b0;
         busy_ff <= 1'b0;
         tgt_eip_ff <= 32'h0;
         tgt_cs_ff <= 16'h0;
         sel_ff <= 16'h0;
         lo_ff <= 32'h0;
         sp_ff <= 32'h0;
         ss_new_ff <= 16'h0;
         cnt_ff <= 5'h00;
         step_ff <= 2'h0;
         wide_ff <= 1'b0;
         data_ff <= 32'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         req_ff <= nxt_req;
         mem_ff <= nxt_mem;
         res_ff <= nxt_res;
         res_valid_ff <= nxt_res_valid;
         busy_ff <= nxt_busy;
         tgt_eip_ff <= nxt_tgt_eip;
         tgt_cs_ff <= nxt_tgt_cs;
         sel_ff <= nxt_sel;
         lo_ff <= nxt_lo;
         sp_ff <= nxt_sp;
         ss_new_ff <= nxt_ss_new;
         cnt_ff <= nxt_cnt;
         step_ff <= nxt_step;
         wide_ff <= nxt_wide;
         data_ff <= nxt_data;
      end
   end

   assign o_busy = busy_ff;
   assign o_mem = mem_ff;
   assign o_res_valid = res_valid_ff;
   assign o_res = res_ff;

   // checks on finished calls, pushes, null selectors and gate parameter counts
   a_near_cs_keep: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (res_valid_ff && !res_ff.fault && (kind == K_NEAR_REL || kind == K_NEAR_ABS)) |-> res_ff.cs == req_ff.cs)
      else $error("near call changed code selector");
   a_op16_upper: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (res_valid_ff && !res_ff.fault && !res_ff.task_switch && !req_ff.op32 && kind != K_FAR_IMM
      && kind != K_FAR_MEM) |-> res_ff.instruction_pointer[31:16] == 16'h0000)
      else $error("upper pointer half not cleared");
   a_fault_keep: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (res_valid_ff && res_ff.fault) |-> (res_ff.instruction_pointer == req_ff.cur_eip && res_ff.cs == req_ff.cs
      && res_ff.stack_pointer == req_ff.stack_pointer))
      else $error("faulted call changed state");
   a_rel_target: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (res_valid_ff && !res_ff.fault && kind == K_NEAR_REL && req_ff.op32) |->
      res_ff.instruction_pointer == req_ff.next_eip + req_ff.imm)
      else $error("relative target wrong");
   a_push_dec: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == ST_PUSH && mem_ff.valid && i_mem_ack) |=> sp_ff == $past(mem_ff.addr))
      else $error("push did not predecrement");
   a_null_sel: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == ST_FAR_CHK && req_ff.prot_mode && sel_ff[15:2] == 14'h0000) |=>
      (res_valid_ff && res_ff.fault && res_ff.vec == VEC_GP && res_ff.err == 16'h0000))
      else $error("null selector not faulted");
   a_param_mask: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == ST_DESC_HI && mem_ff.valid && i_mem_ack && nxt_state == ST_TSS_SP) |=>
      cnt_ff == $past(i_mem_rdata[4:0]))
      else $error("parameter count not masked");
   a_task_prot: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (res_valid_ff && res_ff.task_switch) |-> req_ff.prot_mode)
      else $error("task switch outside protected mode");
   a_near_push: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (state_ff == ST_PUSH && step_ff == STEP_RET_PTR && mem_ff.valid) |->
      (mem_ff.write && mem_ff.wdata == req_ff.next_eip))
      else $error("return pointer not pushed");
endmodule

// File: pcc_pkg.sv
// Functional notes
// - E8 decodes as near relative call
// - FF reg 2 decodes as near indirect
// - 9A decodes as far immediate-pointer call
// - FF reg 3 decodes as far memory-pointer call
// - near call pushes return pointer, then jumps
// - relative displacement sign-extended, added to next pointer
// - stack-based indirect address uses pre-call stack pointer
// - operand size picks absolute target width
// - 16-bit operand size zeroes upper pointer half, except through a call gate, where gate size decides
// - near call keeps code selector unchanged
// - far call pushes code selector and pointer
// - far pointer is four or six bytes
// - far call loads selector and sized offset
// - gates and task switches only in protected mode
// - descriptor type selects call flavour
// - gate gives code segment, task segment gives stack
// - new stack: old stack, parameters, return linkage
// - parameter count comes from gate descriptor
// - gated entry offset comes from target operand
// - task call accepts task gate or task segment
// - no room for return address gives stack fault
// - parameter count masked to five bits
// - null far selector gives protection fault zero
package pcc_pkg;
   localparam logic [7:0] OPC_NEAR_REL = 8'he8;
   localparam logic [7:0] OPC_GROUP = 8'hff;
   localparam logic [7:0] OPC_FAR_IMM = 8'h9a;
   localparam logic [2:0] REG_NEAR_IND = 3'h2;
   localparam logic [2:0] REG_FAR_IND = 3'h3;
   localparam logic [7:0] VEC_GP = 8'h0d;
   localparam logic [7:0] VEC_SS = 8'h0c;
   localparam logic [7:0] VEC_UD = 8'h06;
   localparam int DESC_S_BIT = 12;
   localparam int DESC_TYPE_MSB = 11;
   localparam int DESC_TYPE_LSB = 8;
   localparam int DESC_PCNT_MSB = 4;
   localparam logic [2:0] TYPE_CALL_GATE = 3'h4;
   localparam logic [3:0] TYPE_TASK_GATE = 4'h5;
   localparam logic [3:0] TYPE_TSS16 = 4'h1;
   localparam logic [3:0] TYPE_TSS32 = 4'h9;
   localparam logic [31:0] TSS_SP_OFFSET = 32'h0000_0004;
   localparam logic [31:0] TSS_SS_OFFSET = 32'h0000_0008;
   localparam logic [31:0] DESC_HI_OFFSET = 32'h0000_0004;
   localparam logic [31:0] SZ16 = 32'h0000_0002;
   localparam logic [31:0] SZ32 = 32'h0000_0004;
   localparam logic [15:0] LOW_MASK16 = 16'h0000;
   localparam logic [1:0] STEP_OLD_SS = 2'h0;
   localparam logic [1:0] STEP_CODE_SEL = 2'h2;
   localparam logic [1:0] STEP_RET_PTR = 2'h3;

   typedef enum logic [3:0] {ST_IDLE, ST_DECODE, ST_NEAR_RD, ST_FPTR_OFF, ST_FPTR_SEL, ST_FAR_CHK,
      ST_DESC_LO, ST_DESC_HI, ST_TSS_SP, ST_TSS_SS, ST_PUSH, ST_COPY_RD, ST_COPY_WR} pcc_state_type;
   typedef enum logic [2:0] {K_ILLEGAL, K_NEAR_REL, K_NEAR_ABS, K_FAR_IMM, K_FAR_MEM} pcc_kind_type;

   typedef struct packed {
      logic [7:0] opcode;
      logic [2:0] modrm_reg;
      logic op32;
      logic [31:0] imm;
      logic [15:0] imm_sel;
      logic rm_is_mem;
      logic base_is_sp;
      logic [31:0] rm_value;
      logic [31:0] cur_eip;
      logic [31:0] next_eip;
      logic [15:0] cs;
      logic [31:0] stack_pointer;
      logic [15:0] ss;
      logic prot_mode;
      logic [1:0] cpl;
      logic [31:0] stack_limit;
      logic [31:0] gdt_base;
      logic [31:0] tss_base;
   } pcc_req_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic wide;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pcc_mem_req_type;

   typedef struct packed {
      logic [31:0] instruction_pointer;
      logic [15:0] cs;
      logic [31:0] stack_pointer;
      logic [15:0] ss;
      logic fault;
      logic [7:0] vec;
      logic [15:0] err;
      logic task_switch;
      logic [15:0] task_sel;
   } pcc_res_type;

   localparam pcc_mem_req_type MEM_RESET = '0;
   localparam pcc_res_type RES_RESET = '0;
   localparam pcc_req_type REQ_RESET = '0;
endpackage

// File: pcc_decode.sv
`timescale 1ns/100ps
module pcc_decode
   import pcc_pkg::*;
(
   input wire pcc_pkg::pcc_req_type i_req,
   output pcc_pkg::pcc_kind_type o_kind,
   output logic [31:0] o_near_target
);
   logic [31:0] rel_sum;
   logic [31:0] disp_ext;

   // opcode and reg field pick the call flavour
   always_comb
   begin
      o_kind = K_ILLEGAL;
      if (i_req.opcode == OPC_NEAR_REL)
         o_kind = K_NEAR_REL;
      else if (i_req.opcode == OPC_FAR_IMM)
         o_kind = K_FAR_IMM;
      else if (i_req.opcode == OPC_GROUP && i_req.modrm_reg == REG_NEAR_IND)
         o_kind = K_NEAR_ABS;
      else if (i_req.opcode == OPC_GROUP && i_req.modrm_reg == REG_FAR_IND)
         o_kind = K_FAR_MEM;
   end

   // displacement widened by sign, sum trimmed under 16-bit size
   always_comb
   begin
      disp_ext = i_req.op32 ? i_req.imm : {{16{i_req.imm[15]}}, i_req.imm[15:0]};
      rel_sum = i_req.next_eip + disp_ext;
      if (o_kind == K_NEAR_REL)
         o_near_target = i_req.op32 ? rel_sum : {LOW_MASK16, rel_sum[15:0]};
      else
         o_near_target = i_req.op32 ? i_req.rm_value : {LOW_MASK16, i_req.rm_value[15:0]};
   end
endmodule

// File: pcc_mem_model.sv
`timescale 1ns/100ps
module pcc_mem_model
   import pcc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire pcc_pkg::pcc_mem_req_type i_mem,
   input wire logic [3:0] i_lat,
   output logic o_mem_ack,
   output logic [31:0] o_mem_rdata
);
   logic [31:0] m [logic [31:0]];
   logic [31:0] wa[$];
   logic [31:0] wd[$];
   logic [3:0] cnt_ff;
   logic done_ff;
   // ack after i_lat waits; read data scrambles outside the ack cycle
   always @(posedge i_mclk)
   begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      if (i_sys_rst)
         o_mem_rdata <= 32'h0000_0000;
      if (i_sys_rst || !i_mem.valid)
      begin
         cnt_ff <= 4'h0;
         done_ff <= 1'b0;
      end
      else if (!done_ff && cnt_ff >= i_lat)
      begin
         o_mem_ack <= 1'b1;
         done_ff <= 1'b1;
         if (i_mem.write)
         begin
            m[i_mem.addr] = i_mem.wdata;
            wa.push_back(i_mem.addr);
            wd.push_back(i_mem.wide ? i_mem.wdata : {16'h0000, i_mem.wdata[15:0]}); // narrow push keeps 2 bytes
         end
         else
            o_mem_rdata <= m.exists(i_mem.addr) ? m[i_mem.addr] : 32'h0000_0000;
      end
      else
         cnt_ff <= cnt_ff + 4'h1;
   end
endmodule

// File: procedure_call_control_tb.sv
`timescale 1ns/100ps
module procedure_call_control_tb;
   import pcc_pkg::*;
   logic i_mclk, i_sys_rst, i_req_valid, ack, o_busy, o_res_valid;
   logic [31:0] rdata;
   logic [3:0] lat;
   pcc_req_type i_req, r;
   pcc_mem_req_type o_mem;
   pcc_res_type o_res, res;
   int n_mismatch = 0;
   int check_count = 0;
   pcc_call_ctrl dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req),
      .i_mem_ack(ack), .i_mem_rdata(rdata), .o_busy(o_busy), .o_mem(o_mem), .o_res_valid(o_res_valid),
      .o_res(o_res));
   pcc_mem_model mem_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mem(o_mem), .i_lat(lat),
      .o_mem_ack(ack), .o_mem_rdata(rdata));
   // free running core clock, 100 ns period
   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   task print_verdict;
      if (n_mismatch == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task chkw(input int i, input logic [31:0] a, input logic [31:0] d);
      chk("push_addr", a, mem_u.wa[i]);
      chk("push_data", d, mem_u.wd[i]);
   endtask
   // common request: real mode, 32-bit, roomy stack
   task base;
      r = REQ_RESET;
      r.op32 = 1'b1;
      r.next_eip = 32'h0000_1000;
      r.cur_eip = 32'h0000_0ffb;
      r.cs = 16'h0010;
      r.stack_pointer = 32'h0000_2000;
      r.ss = 16'h0023;
      r.gdt_base = 32'h0000_4000;
      r.tss_base = 32'h0000_6000;
      lat = 4'h0;
   endtask
   // one request, bounded wait for the result pulse
   task go;
      mem_u.wa.delete();
      mem_u.wd.delete();
      @(posedge i_mclk);
      i_req <= r;
      i_req_valid <= 1'b1;
      @(posedge i_mclk);
      i_req_valid <= 1'b0;
      #1;
      chk("busy", 32'h0000_0001, {31'h0, o_busy});
      for (int k = 0; k < 300; k++)
      begin
         #1;
         if (o_res_valid === 1'b1)
            break;
         @(posedge i_mclk);
      end
      if (o_res_valid !== 1'b1)
      begin
         n_mismatch++;
         print_verdict;
      end
      else
      begin
         res = o_res;
         chk("busy_end", 32'h0000_0000, {31'h0, o_busy});
      end
   endtask
   task s_near_reg16;
      base;
      r.op32 = 1'b0;
      r.opcode = OPC_GROUP;
      r.modrm_reg = REG_NEAR_IND;
      r.rm_value = 32'habcd_1234;
      go;
      chk("eip", 32'h0000_1234, res.instruction_pointer);
      chk("esp", 32'h0000_1ffe, res.stack_pointer);
      chkw(0, 32'h0000_1ffe, 32'h0000_1000);
   endtask
   task s_illegal;
      base;
      r.opcode = 8'h90;
      go;
      chk("fault", 32'h0000_0001, res.fault);
      chk("vec", {24'h0, VEC_UD}, {24'h0, res.vec});
      chk("eip", 32'h0000_0ffb, res.instruction_pointer);
   endtask
   task s_code_seg;
      base;
      r.opcode = OPC_FAR_IMM;
      r.prot_mode = 1'b1;
      r.cpl = 2'h2;
      r.imm = 32'h0000_7000;
      r.imm_sel = 16'h0030;
      mem_u.m[32'h0000_4034] = 32'h0000_9a00;
      go;
      chk("cs", 32'h0000_0032, res.cs);
      chk("eip", 32'h0000_7000, res.instruction_pointer);
      chkw(0, 32'h0000_1ffc, 32'h0000_0010);
      chkw(1, 32'h0000_1ff8, 32'h0000_1000);
   endtask
   task s_near_rel;
      base;
      r.opcode = OPC_NEAR_REL;
      r.imm = 32'hffff_fff0;
      go;
      chk("eip", 32'h0000_0ff0, res.instruction_pointer);
      chk("cs", 32'h0000_0010, res.cs);
      chk("esp", 32'h0000_1ffc, res.stack_pointer);
      chkw(0, 32'h0000_1ffc, 32'h0000_1000);
   endtask
   task s_near_ind;
      base;
      r.opcode = OPC_GROUP;
      r.modrm_reg = REG_NEAR_IND;
      r.rm_is_mem = 1'b1;
      r.base_is_sp = 1'b1;
      r.rm_value = 32'h0000_0008;
      mem_u.m[32'h0000_2008] = 32'h1234_5678;
      mem_u.m[32'h0000_2004] = 32'hdead_0000;
      lat = 4'h2;
      go;
      chk("eip", 32'h1234_5678, res.instruction_pointer);
   endtask
   task s_far_imm;
      base;
      r.opcode = OPC_FAR_IMM;
      r.imm = 32'h0000_5000;
      r.imm_sel = 16'h0020;
      go;
      chk("cs", 32'h0000_0020, res.cs);
      chk("eip", 32'h0000_5000, res.instruction_pointer);
      chkw(0, 32'h0000_1ffc, 32'h0000_0010);
      chkw(1, 32'h0000_1ff8, 32'h0000_1000);
   endtask
   task s_far_mem16;
      base;
      r.op32 = 1'b0;
      r.opcode = OPC_GROUP;
      r.modrm_reg = REG_FAR_IND;
      r.rm_is_mem = 1'b1;
      r.rm_value = 32'h0000_3000;
      mem_u.m[32'h0000_3000] = 32'hffff_1111;
      mem_u.m[32'h0000_3002] = 32'hbeef_0040;
      go;
      chk("eip", 32'h0000_1111, res.instruction_pointer);
      chk("cs", 32'h0000_0040, res.cs);
      chkw(1, 32'h0000_1ffc, 32'h0000_1000);
   endtask
   task s_stack_fault;
      base;
      r.opcode = OPC_NEAR_REL;
      r.stack_pointer = 32'h0000_0002;
      r.stack_limit = 32'h0000_0100;
      go;
      chk("fault", 32'h0000_0001, res.fault);
      chk("vec", {24'h0, VEC_SS}, {24'h0, res.vec});
      chk("err", 32'h0000_0000, res.err);
      chk("eip", 32'h0000_0ffb, res.instruction_pointer);
      chk("esp", 32'h0000_0002, res.stack_pointer);
      chk("pushes", 32'h0000_0000, mem_u.wa.size());
   endtask
   task s_null_sel;
      base;
      r.opcode = OPC_FAR_IMM;
      r.prot_mode = 1'b1;
      go;
      chk("vec", {24'h0, VEC_GP}, {24'h0, res.vec});
      chk("err", 32'h0000_0000, res.err);
      chk("fault", 32'h0000_0001, res.fault);
      chk("cs", 32'h0000_0010, res.cs);
   endtask
   task s_task_seg;
      base;
      r.opcode = OPC_FAR_IMM;
      r.prot_mode = 1'b1;
      r.imm_sel = 16'h0018;
      mem_u.m[32'h0000_401c] = 32'h0000_8900;
      go;
      chk("task", 32'h0000_0001, res.task_switch);
      chk("sel", 32'h0000_0018, res.task_sel);
   endtask
   // gate with privilege change, slow memory, count field has junk above bit 4
   task s_gate;
      logic [31:0] ea[6] = '{32'h8ffc, 32'h8ff8, 32'h8ff4, 32'h8ff0, 32'h8fec, 32'h8fe8};
      logic [31:0] ed[6] = '{32'h0023, 32'h2000, 32'hbbbb_0002, 32'haaaa_0001, 32'h001b, 32'h1000};
      base;
      r.opcode = OPC_FAR_IMM;
      r.prot_mode = 1'b1;
      r.cpl = 2'h3;
      r.cs = 16'h001b;
      r.imm = 32'h0000_3456;
      r.imm_sel = 16'h0028;
      mem_u.m[32'h0000_4028] = 32'h0008_0000;
      mem_u.m[32'h0000_402c] = 32'h0000_ece2;
      mem_u.m[32'h0000_6004] = 32'h0000_9000;
      mem_u.m[32'h0000_6008] = 32'h0000_0010;
      mem_u.m[32'h0000_2000] = 32'haaaa_0001;
      mem_u.m[32'h0000_2004] = 32'hbbbb_0002;
      lat = 4'h3;
      go;
      for (int i = 0; i < 6; i++)
         chkw(i, ea[i], ed[i]);
      chk("pushes", 32'h0000_0006, mem_u.wa.size());
      chk("cs", 32'h0000_0008, res.cs);
      chk("ss", 32'h0000_0010, res.ss);
      chk("eip", 32'h0000_3456, res.instruction_pointer);
      chk("esp", 32'h0000_8fe8, res.stack_pointer);
   endtask
   initial
   begin
      i_sys_rst = 1'b1;
      i_req_valid = 1'b0;
      i_req = REQ_RESET;
      lat = 4'h0;
      repeat (5) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      s_near_rel;
      s_near_ind;
      s_far_imm;
      s_far_mem16;
      s_near_reg16;
      s_illegal;
      s_code_seg;
      s_stack_fault;
      s_null_sel;
      s_task_seg;
      s_gate;
      print_verdict;
   end
endmodule
